// File: core/pei_plane_interp.sv
// plane equation interpolator: accumulators, multiplexer, site evaluator
// assumes tiler, setup and memory path all run on clock_in
//
// Behaviour
// - sites sit at whole pixels, subpixel offsets 0, 8, 16, 24, pixel offset = subpixel / 8.
// - each accumulator holds its plane constant and steps on a horizontal or vertical step.
// - a horizontal step adds the stored increment of minus 32 times the x slope.
// - constants and slopes carry sixteen fraction bits.
// - one extra high integer bit is kept so compares see overflow and underflow.
// - the narrow accumulator uses 9 integer and 16 fraction bits per color equation.
// - the wide accumulator uses 25 integer and 16 fraction bits for its one equation.
// - three color equations step together, the wide one steps a single equation.
// - accumulator outputs reach the site evaluator through a multiplexer.
// - the site evaluator is 27 bits wide, one 25-bit lane or three 9-bit lanes.
// - site values drop the fraction, so setup may err by up to one unit.
// - the site evaluator combines memory data with interpolated values in ALUs.
// - high bits of intermediate results may be dropped.
// - 8-bit results clamp: overflow to maximum, underflow to minimum.
// - an 8-bit operation on the depth equation copies its value into all three lanes.
`timescale 1ns/10ps
module pei_plane_interp
   import pei_pkg::*;
(
   input  wire logic           clock_in,
   input  wire logic           rst_in,
   input  wire pei_step_s      step_in,
   input  wire logic           color_load_in,
   input  pei_narrow_eq_s      color_eq_in [LANES],
   input  wire logic           depth_load_in,
   input  wire pei_wide_eq_s   depth_eq_in,
   input  wire logic           eval_in,
   input  wire pei_mode_e      lane_mode_in,
   input  wire pei_src_e       source_in,
   input  wire pei_op_e        op_in,
   input  wire pei_pixels_t    mem_rd_data_in,
   output pei_pixels_t         result_out,
   output pei_flags_t          flag_out,
   output logic                result_valid_out
);

   ////////////////////////////////////////////////////////////////////////////
   // accumulator outputs
   logic [NARROW_W-1:0] n_c  [LANES];
   logic [NARROW_W-1:0] n_sx [LANES];
   logic [NARROW_W-1:0] n_sy [LANES];
   logic [WIDE_W-1:0]   w_c;
   logic [WIDE_W-1:0]   w_sx;
   logic [WIDE_W-1:0]   w_sy;

   // multiplexed equation per lane, at wide precision
   logic [WIDE_W-1:0]   m_c  [LANES];
   logic [WIDE_W-1:0]   m_sx [LANES];
   logic [WIDE_W-1:0]   m_sy [LANES];
   // select
   logic                use_wide;

   // site stage
   logic [SITE_W-1:0]   site_q [SITES];
   logic [SITE_W-1:0]   site_d [SITES];
   // captured request
   pei_pixels_t         mem_q,  mem_d;
   pei_op_e             op_q,   op_d;
   pei_mode_e           mode_q, mode_d;
   logic                go_q,   go_d;

   // result stage
   pei_pixels_t         result_q, result_d;
   pei_flags_t          flag_q,   flag_d;
   // new result strobe
   logic                valid_q,  valid_d;

   ////////////////////////////////////////////////////////////////////////////
   // site value at subpixel offset (8*dx, 8*dy) from the array origin
   function automatic logic [WIDE_W-1:0] site_fn(
      input logic [WIDE_W-1:0] c,
      input logic [WIDE_W-1:0] sx,
      input logic [WIDE_W-1:0] sy,
      input logic [1:0]        dx,
      input logic [1:0]        dy
   );
      logic [WIDE_W-1:0] tx;
      logic [WIDE_W-1:0] ty;

      // offsets 0, 8, 16, 24 built from shifted slopes
      tx = (dx[0] ? (sx << SUBPIX_SHIFT) : '0)
         + (dx[1] ? (sx << (SUBPIX_SHIFT + 1)) : '0);
      ty = (dy[0] ? (sy << SUBPIX_SHIFT) : '0)
         + (dy[1] ? (sy << (SUBPIX_SHIFT + 1)) : '0);

      return c - tx - ty;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // three narrow accumulators stepping in parallel
   genvar l;

   generate
      for (l = 0; l < LANES; l++) begin : g_narrow
         pei_plane_acc #(
            .WIDTH        (NARROW_W)
         ) u_narrow_plane_accumulator (
            .clock_in     (clock_in),
            .rst_in       (rst_in),
            .load_in      (color_load_in),
            .constant_in  (color_eq_in[l].constant),
            .slope_x_in   (color_eq_in[l].slope_x),
            .slope_y_in   (color_eq_in[l].slope_y),
            .step_in      (step_in),
            .constant_out (n_c[l]),
            .slope_x_out  (n_sx[l]),
            .slope_y_out  (n_sy[l])
         );
      end
   endgenerate


   // single wide accumulator
   pei_plane_acc #(
      .WIDTH        (WIDE_W)
   ) u_wide_plane_accumulator (
      .clock_in     (clock_in),
      .rst_in       (rst_in),
      .load_in      (depth_load_in),
      .constant_in  (depth_eq_in.constant),
      .slope_x_in   (depth_eq_in.slope_x),
      .slope_y_in   (depth_eq_in.slope_y),
      .step_in      (step_in),
      .constant_out (w_c),
      .slope_x_out  (w_sx),
      .slope_y_out  (w_sy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // multiplexer into the site evaluator
   assign use_wide = (lane_mode_in == PEI_MODE_SINGLE)
                   | (source_in == PEI_SRC_DEPTH);


   generate
      for (l = 0; l < LANES; l++) begin : g_mux
         always_comb begin
            if (use_wide) begin
               // depth value copied into every lane
               m_c[l]  = w_c;
               m_sx[l] = w_sx;
               m_sy[l] = w_sy;
            end else begin
               // sign extend
               m_c[l]  = {{(WIDE_W-NARROW_W){n_c[l][NARROW_W-1]}}, n_c[l]};
               m_sx[l] = {{(WIDE_W-NARROW_W){n_sx[l][NARROW_W-1]}}, n_sx[l]};
               m_sy[l] = {{(WIDE_W-NARROW_W){n_sy[l][NARROW_W-1]}}, n_sy[l]};
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // per-site setup: fraction dropped, integer part kept
   genvar s;

   generate
      for (s = 0; s < SITES; s++) begin : g_site
         localparam logic [1:0] DX = 2'(s % ARRAY_DIM);
         localparam logic [1:0] DY = 2'(s / ARRAY_DIM);
         logic [WIDE_W-1:0] full [LANES];

         always_comb begin
            for (int k = 0; k < LANES; k++) begin
               full[k] = site_fn(m_c[k], m_sx[k], m_sy[k], DX, DY);
            end

            if (lane_mode_in == PEI_MODE_SINGLE) begin
               // one 25-bit lane in the low bits
               site_d[s] = {2'b00, full[0][FRAC_W +: WIDE_INT_W]};
            end else begin
               // three 9-bit lanes, lane 2 is red
               site_d[s] = {full[2][FRAC_W +: LANE_W],
                            full[1][FRAC_W +: LANE_W],
                            full[0][FRAC_W +: LANE_W]};
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // site stage capture on an evaluate request
   always_comb begin
      mem_d  = eval_in ? mem_rd_data_in : mem_q;
      op_d   = eval_in ? op_in : op_q;
      mode_d = eval_in ? lane_mode_in : mode_q;

      go_d   = eval_in;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int k = 0; k < SITES; k++) begin
            site_q[k] <= '0;
         end
         mem_q  <= '0;
         op_q   <= PEI_OP_PASS;
         mode_q <= PEI_MODE_SINGLE;
         go_q   <= 1'b0;
      end else begin
         for (int k = 0; k < SITES; k++) begin
            site_q[k] <= eval_in ? site_d[k] : site_q[k];
         end

         mem_q  <= mem_d;
         op_q   <= op_d;
         mode_q <= mode_d;
         go_q   <= go_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-site ALUs combining memory data with site values
   generate
      for (s = 0; s < SITES; s++) begin : g_alu
         logic signed [LANE_W:0]     a8;
         logic signed [LANE_W:0]     m8;
         logic signed [LANE_W:0]     r8;
         logic [WIDE_INT_W-1:0]      a24;
         logic [WIDE_INT_W-1:0]      m24;
         logic [WIDE_INT_W-1:0]      r24;

         always_comb begin
            // hold by default
            a8  = '0;
            m8  = '0;
            r8  = '0;
            r24 = '0;
            a24 = site_q[s][WIDE_INT_W-1:0];
            m24 = {1'b0, mem_q[s]};
            result_d[s] = result_q[s];
            flag_d[s]   = flag_q[s];
            if (go_q && (mode_q == PEI_MODE_TRIPLE)) begin
               for (int k = 0; k < LANES; k++) begin
                  a8 = {site_q[s][k*LANE_W + LANE_W-1], site_q[s][k*LANE_W +: LANE_W]};
                  m8 = {2'b00, mem_q[s][k*COLOR_W +: COLOR_W]};

                  case (op_q)
                     PEI_OP_PASS: r8 = a8;
                     PEI_OP_ADD:  r8 = m8 + a8;
                     PEI_OP_SUB:  r8 = m8 - a8;
                     PEI_OP_AND:  r8 = m8 & a8 & 10'sh0ff;
                     PEI_OP_OR:   r8 = (m8 | a8) & 10'sh0ff;
                     PEI_OP_XOR:  r8 = (m8 ^ a8) & 10'sh0ff;
                     default:     r8 = a8;
                  endcase
                  // out-of-range seen through the extra high bits
                  flag_d[s][k] = (r8 < 0) || (r8 > 10'sh0ff);

                  if (r8 < 0) begin
                     result_d[s][k*COLOR_W +: COLOR_W] = COLOR_MIN;
                  end else if (r8 > 10'sh0ff) begin
                     result_d[s][k*COLOR_W +: COLOR_W] = COLOR_MAX;
                  end else begin
                     result_d[s][k*COLOR_W +: COLOR_W] = r8[COLOR_W-1:0];
                  end
               end
            end else if (go_q) begin
               // wraps
               case (op_q)
                  PEI_OP_PASS: r24 = a24;
                  PEI_OP_ADD:  r24 = m24 + a24;
                  PEI_OP_SUB:  r24 = m24 - a24;
                  PEI_OP_AND:  r24 = m24 & a24;
                  PEI_OP_OR:   r24 = m24 | a24;
                  PEI_OP_XOR:  r24 = m24 ^ a24;
                  default:     r24 = a24;
               endcase

               // no clamp on the wide lane, extra bit reports overflow
               result_d[s] = r24[DEPTH_W-1:0];
               flag_d[s]   = {LANES{r24[WIDE_INT_W-1]}};
            end
         end
      end
   endgenerate

   // two edges after eval
   always_comb begin
      valid_d = go_q;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         result_q <= '0;
         flag_q   <= '0;
         valid_q  <= 1'b0;
      end else begin

         result_q <= result_d;
         flag_q   <= flag_d;
         valid_q  <= valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign result_out       = result_q;
   assign flag_out         = flag_q;
   assign result_valid_out = valid_q;

endmodule

// File: common/pei_pkg.sv
// constants, carriers and enumerations of the plane equation interpolator
// assumes one rendering clock shared with the tiler and the memory path
package pei_pkg;

   // fixed point layout of plane constants and slope terms
   localparam int FRAC_W       = 16;
   localparam int NARROW_INT_W = 9;
   localparam int WIDE_INT_W   = 25;
   localparam int NARROW_W     = NARROW_INT_W + FRAC_W;
   localparam int WIDE_W       = WIDE_INT_W + FRAC_W;

   // lane layout of the site evaluator
   localparam int LANES   = 3;
   localparam int LANE_W  = 9;
   localparam int SITE_W  = 27;
   localparam int COLOR_W = 8;
   localparam int DEPTH_W = 24;

   // update array geometry and stepping
   localparam int ARRAY_DIM    = 4;
   localparam int SITES        = 16;
   localparam int SUBPIX_SHIFT = 3;
   localparam int STEP_SHIFT   = 5;

   // clamp limits of 8-bit channels
   localparam logic [COLOR_W-1:0] COLOR_MAX = 8'hff;
   localparam logic [COLOR_W-1:0] COLOR_MIN = 8'h00;

   typedef struct packed {
      logic step_horizontal;
      logic step_vertical;
   } pei_step_s;

   typedef struct packed {
      logic [NARROW_W-1:0] constant;
      logic [NARROW_W-1:0] slope_x;
      logic [NARROW_W-1:0] slope_y;
   } pei_narrow_eq_s;

   typedef struct packed {
      logic [WIDE_W-1:0] constant;
      logic [WIDE_W-1:0] slope_x;
      logic [WIDE_W-1:0] slope_y;
   } pei_wide_eq_s;

   typedef enum logic [0:0] {
      PEI_MODE_SINGLE = 1'b0,
      PEI_MODE_TRIPLE = 1'b1
   } pei_mode_e;

   typedef enum logic [0:0] {
      PEI_SRC_COLOR = 1'b0,
      PEI_SRC_DEPTH = 1'b1
   } pei_src_e;

   typedef enum logic [2:0] {
      PEI_OP_PASS = 3'b000,
      PEI_OP_ADD  = 3'b001,
      PEI_OP_SUB  = 3'b010,
      PEI_OP_AND  = 3'b011,
      PEI_OP_OR   = 3'b100,
      PEI_OP_XOR  = 3'b101
   } pei_op_e;

   typedef logic [SITES-1:0][DEPTH_W-1:0] pei_pixels_t;
   typedef logic [SITES-1:0][LANES-1:0]   pei_flags_t;

endpackage

// File: core/pei_plane_acc.sv
// one plane constant accumulator stepped by the tiler
// assumes slopes are per subpixel and the update array is 4x4
`timescale 1ns/10ps
module pei_plane_acc
   import pei_pkg::*;
#(
   parameter int WIDTH = NARROW_W
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] constant_in,
   input  wire logic [WIDTH-1:0] slope_x_in,
   input  wire logic [WIDTH-1:0] slope_y_in,
   input  wire pei_step_s        step_in,
   output logic      [WIDTH-1:0] constant_out,
   output logic      [WIDTH-1:0] slope_x_out,
   output logic      [WIDTH-1:0] slope_y_out
);

   logic [WIDTH-1:0] acc_q,   acc_d;
   logic [WIDTH-1:0] sx_q,    sx_d;
   logic [WIDTH-1:0] sy_q,    sy_d;
   logic [WIDTH-1:0] inc_x_q, inc_x_d;
   logic [WIDTH-1:0] inc_y_q, inc_y_d;

   ////////////////////////////////////////////////////////////////////////////
   // load wins over a step in the same cycle; both steps may add together
   always_comb begin
      acc_d   = acc_q;
      sx_d    = sx_q;
      sy_d    = sy_q;
      inc_x_d = inc_x_q;
      inc_y_d = inc_y_q;
      if (load_in) begin
         acc_d   = constant_in;
         sx_d    = slope_x_in;
         sy_d    = slope_y_in;
         inc_x_d = '0 - (slope_x_in << STEP_SHIFT);
         inc_y_d = '0 - (slope_y_in << STEP_SHIFT);
      end else begin
         // high bits may wrap; only in-primitive values matter
         acc_d = acc_q
               + (step_in.step_horizontal ? inc_x_q : '0)
               + (step_in.step_vertical   ? inc_y_q : '0);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         acc_q   <= '0;
         sx_q    <= '0;
         sy_q    <= '0;
         inc_x_q <= '0;
         inc_y_q <= '0;
      end else begin
         acc_q   <= acc_d;
         sx_q    <= sx_d;
         sy_q    <= sy_d;
         inc_x_q <= inc_x_d;
         inc_y_q <= inc_y_d;
      end
   end

   assign constant_out = acc_q;
   assign slope_x_out  = sx_q;
   assign slope_y_out  = sy_q;

endmodule

// File: tb/pei_plane_interp_sva.sv
// checker for the plane interpolator top, watching its ports only
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
module pei_plane_interp_sva
   import pei_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        eval_in,
   input wire pei_mode_e   lane_mode_in,
   input wire pei_src_e    source_in,
   input wire pei_op_e     op_in,
   input wire pei_pixels_t mem_rd_data_in,
   input wire pei_pixels_t result_out,
   input wire pei_flags_t  flag_out,
   input wire logic        result_valid_out
);
   logic uni_ok;
   logic clamp_ok;
   logic rep_ok;

   // per site summaries: uniform flags, clamped bytes, replicated bytes
   always_comb begin
      uni_ok   = 1'b1;
      clamp_ok = 1'b1;
      rep_ok   = 1'b1;
      for (int s = 0; s < SITES; s++) begin
         uni_ok &= (flag_out[s] == 3'b000) || (flag_out[s] == 3'b111);
         rep_ok &= (result_out[s][23:16] == result_out[s][7:0]);
         rep_ok &= (result_out[s][15:8] == result_out[s][7:0]);
         for (int k = 0; k < LANES; k++) begin
            if (flag_out[s][k]) begin
               clamp_ok &= result_out[s][8*k+:8] inside {COLOR_MIN, COLOR_MAX};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   sequence s_answer;
      ##2 result_valid_out;
   endsequence
   sequence s_taken_arith;
      eval_in && lane_mode_in == PEI_MODE_TRIPLE
         && op_in inside {PEI_OP_PASS, PEI_OP_ADD, PEI_OP_SUB};
   endsequence

   property p_answer;
      eval_in |-> s_answer;
   endproperty
   property p_no_spurious;
      result_valid_out |-> $past(eval_in, 2);
   endproperty
   property p_hold;
      !result_valid_out |-> $stable(result_out) && $stable(flag_out);
   endproperty
   property p_single_flags;
      eval_in && lane_mode_in == PEI_MODE_SINGLE |-> ##2 uni_ok;
   endproperty
   property p_clamp;
      s_taken_arith |-> ##2 clamp_ok;
   endproperty
   property p_replicate;
      eval_in && lane_mode_in == PEI_MODE_TRIPLE && source_in == PEI_SRC_DEPTH
         && op_in == PEI_OP_PASS |-> ##2 (rep_ok && uni_ok);
   endproperty
   property p_and_mask;
      eval_in && op_in == PEI_OP_AND |-> ##2 ((result_out & ~$past(mem_rd_data_in, 2)) == '0);
   endproperty
   property p_or_cover;
      eval_in && op_in == PEI_OP_OR
         |-> ##2 ((result_out & $past(mem_rd_data_in, 2)) == $past(mem_rd_data_in, 2));
   endproperty

   a_answer: assert property (p_answer)
      else $error("no result two cycles after eval");
   a_no_spurious: assert property (p_no_spurious)
      else $error("result without eval two cycles before");
   a_hold: assert property (p_hold)
      else $error("result changed without valid");
   a_single_flags: assert property (p_single_flags)
      else $error("single lane flags differ");
   a_clamp: assert property (p_clamp)
      else $error("flagged color byte not clamped");
   a_replicate: assert property (p_replicate)
      else $error("depth value not replicated");
   a_and_mask: assert property (p_and_mask)
      else $error("and result outside memory bits");
   a_or_cover: assert property (p_or_cover)
      else $error("or result lost memory bits");
endmodule

// File: tb/pei_far_model.sv
// tiler step pulses and graphics memory read data for the interpolator
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/10ps
module pei_far_model
   import pei_pkg::*;
(
   input  wire logic  clock_in,
   output pei_step_s   step_out,
   output pei_pixels_t mem_out
);
   logic [7:0] slow_gap;  // idle cycles of a slow tiler

   initial begin
      step_out = '0;
      mem_out  = '0;
      slow_gap = 8'h00;
   end

   // one step pulse, one clock wide, after the tiler's delay
   task automatic step(input logic h, input logic v);
      repeat (slow_gap) @(negedge clock_in);
      step_out = {h, v};
      @(negedge clock_in);
      step_out = '0;
   endtask

   // memory pixels for all sites
   task automatic present(input logic [7:0] seed);
      for (int s = 0; s < SITES; s++) begin
         mem_out[s] = {seed + 8'(3 * s), seed ^ 8'(16 * s), seed - 8'(s)};
      end
   endtask

   // released bus shows the inverse, never a stale copy
   task automatic release_bus();
      mem_out = ~mem_out;
   endtask
endmodule

// File: tb/pei_plane_interp_tb_top.sv
// self-checking bench of the plane interpolator top
// assumes the far side model and checker files compile before it
`timescale 1ns/10ps
module pei_plane_interp_tb_top
   import pei_pkg::*;
;
   typedef struct packed {
      logic h; logic v; logic [7:0] gap;
      pei_mode_e md; pei_src_e sr; pei_op_e op; logic [7:0] seed;
   } pei_row_s;
   logic           clock_in = 1'b0;
   logic           rst_in = 1'b1;
   logic           color_load_in = 1'b0;
   logic           depth_load_in = 1'b0;
   logic           eval_in = 1'b0;
   pei_narrow_eq_s color_eq_in [LANES] = '{default: '0};
   pei_wide_eq_s   depth_eq_in = '0;
   pei_mode_e      lane_mode_in = PEI_MODE_SINGLE;
   pei_src_e       source_in = PEI_SRC_COLOR;
   pei_op_e        op_in = PEI_OP_PASS;
   pei_step_s      step_in;
   pei_pixels_t    mem_rd_data_in;
   pei_pixels_t    result_out;
   pei_flags_t     flag_out;
   logic           result_valid_out;
   int             bad_count = 0;
   int             checked = 0;
   int             cycles = 0;
   logic [NARROW_W-1:0] ec [LANES];
   logic [NARROW_W-1:0] esx [LANES];
   logic [NARROW_W-1:0] esy [LANES];
   logic [WIDE_W-1:0]   dc, dsx, dsy;
   pei_row_s rows [12] = '{
      '{1'b0, 1'b0, 8'h00, PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_PASS, 8'h11},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_PASS, 8'h22},
      '{1'b1, 1'b0, 8'h03, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_ADD, 8'hf0},
      '{1'b0, 1'b1, 8'h00, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_SUB, 8'h05},
      '{1'b1, 1'b1, 8'h00, PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_ADD, 8'hff},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_SUB, 8'h3c},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_TRIPLE, PEI_SRC_DEPTH, PEI_OP_PASS, 8'h40},
      '{1'b0, 1'b1, 8'h02, PEI_MODE_TRIPLE, PEI_SRC_DEPTH, PEI_OP_ADD, 8'h80},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_AND, 8'ha5},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_OR, 8'h5a},
      '{1'b1, 1'b0, 8'h00, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_XOR, 8'hc3},
      '{1'b0, 1'b0, 8'h00, PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_AND, 8'h96}};

   ////////////////////////////////////////////////////////////////
   always #25 clock_in = ~clock_in;

   // hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results();
      end
   end

   pei_far_model far (.clock_in(clock_in), .step_out(step_in), .mem_out(mem_rd_data_in));
   pei_plane_interp uut (
      .clock_in(clock_in), .rst_in(rst_in), .step_in(step_in),
      .color_load_in(color_load_in), .color_eq_in(color_eq_in),
      .depth_load_in(depth_load_in), .depth_eq_in(depth_eq_in), .eval_in(eval_in),
      .lane_mode_in(lane_mode_in), .source_in(source_in), .op_in(op_in),
      .mem_rd_data_in(mem_rd_data_in), .result_out(result_out), .flag_out(flag_out),
      .result_valid_out(result_valid_out));

   ////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(string what, logic [26:0] seen, logic [26:0] want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask

   // expected {flags, pixel} of one site from the plane state
   function automatic logic [26:0] expect_site(int s, pei_mode_e md, pei_src_e sr,
                                               pei_op_e op, logic [23:0] m);
      logic [WIDE_W-1:0]   dv;
      logic [NARROW_W-1:0] nv;
      logic [24:0]         r;
      logic [8:0]          pl;
      logic [9:0]          q;
      logic [26:0]         o;
      dv = dc - dsx * WIDE_W'(8 * (s % 4)) - dsy * WIDE_W'(8 * (s / 4));
      r = dv[WIDE_W-1:FRAC_W];
      if (md == PEI_MODE_SINGLE) begin
         case (op)
            PEI_OP_PASS: r = r;
            PEI_OP_ADD:  r = {1'b0, m} + r;
            PEI_OP_SUB:  r = {1'b0, m} - r;
            PEI_OP_AND:  r = {1'b0, m} & r;
            PEI_OP_OR:   r = {1'b0, m} | r;
            default:     r = {1'b0, m} ^ r;
         endcase
         return {{3{r[24]}}, r[23:0]};
      end
      o = '0;
      for (int k = 0; k < LANES; k++) begin
         nv = ec[k] - esx[k] * NARROW_W'(8 * (s % 4)) - esy[k] * NARROW_W'(8 * (s / 4));
         pl = (sr == PEI_SRC_DEPTH) ? dv[24:16] : nv[24:16];
         case (op)
            PEI_OP_PASS: q = {pl[8], pl};
            PEI_OP_ADD:  q = {2'b00, m[8*k+:8]} + {pl[8], pl};
            PEI_OP_SUB:  q = {2'b00, m[8*k+:8]} - {pl[8], pl};
            PEI_OP_AND:  q = {2'b00, m[8*k+:8] & pl[7:0]};
            PEI_OP_OR:   q = {2'b00, m[8*k+:8] | pl[7:0]};
            default:     q = {2'b00, m[8*k+:8] ^ pl[7:0]};
         endcase
         o[24+k] = q[9] || q[8];
         o[8*k+:8] = q[9] ? COLOR_MIN : (q[8] ? COLOR_MAX : q[7:0]);
      end
      return o;
   endfunction

   task automatic set_model(logic zero);
      ec  = '{25'h010_0000, 25'h080_4000, 25'h0fa_0000};
      esx = '{25'h001_0000, 25'h000_0000, -25'h000_8000};
      esy = '{25'h000_0000, 25'h000_4000, 25'h000_2000};
      dc  = 41'h000_00c8_8000;
      dsx = 41'h000_0000_4000;
      dsy = -41'h000_0001_8000;
      if (zero) begin
         ec = '{default: '0};
         esx = '{default: '0};
         esy = '{default: '0};
         {dc, dsx, dsy} = '0;
      end
   endtask

   // load both accumulators, optionally beside a step of both axes
   task automatic load_eqs(logic with_step);
      for (int k = 0; k < LANES; k++) color_eq_in[k] = {ec[k], esx[k], esy[k]};
      depth_eq_in = {dc, dsx, dsy};
      color_load_in = 1'b1;
      depth_load_in = 1'b1;
      if (with_step) far.step(1'b1, 1'b1);
      else @(negedge clock_in);
      color_load_in = 1'b0;
      depth_load_in = 1'b0;
   endtask

   task automatic do_step(logic h, logic v);
      far.step(h, v);
      for (int k = 0; k < LANES; k++) begin
         if (h) ec[k] = ec[k] - (esx[k] << STEP_SHIFT);
         if (v) ec[k] = ec[k] - (esy[k] << STEP_SHIFT);
      end
      if (h) dc = dc - (dsx << STEP_SHIFT);
      if (v) dc = dc - (dsy << STEP_SHIFT);
   endtask

   task automatic check_eval(pei_pixels_t m, pei_mode_e md, pei_src_e sr, pei_op_e op);
      check("valid", 27'(result_valid_out), 27'h1);
      for (int s = 0; s < SITES; s++) begin
         check($sformatf("site %0d", s), {flag_out[s], result_out[s]}, expect_site(s, md, sr, op, m[s]));
      end
   endtask

   task automatic do_eval(pei_mode_e md, pei_src_e sr, pei_op_e op, logic [7:0] seed);
      pei_pixels_t m;
      far.present(seed);
      m = far.mem_out;
      {lane_mode_in, source_in, op_in} = {md, sr, op};
      eval_in = 1'b1;
      @(negedge clock_in);
      eval_in = 1'b0;
      far.release_bus();
      @(negedge clock_in);
      check_eval(m, md, sr, op);
   endtask

   task automatic check_idle();
      check("idle valid", 27'(result_valid_out), 27'h0);
      for (int s = 0; s < SITES; s++) check("idle site", {flag_out[s], result_out[s]}, 27'h0);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      pei_pixels_t m;
      set_model(1'b0);
      repeat (5) @(negedge clock_in);
      rst_in = 1'b0;
      check_idle();
      load_eqs(1'b0);
      foreach (rows[i]) begin
         far.slow_gap = rows[i].gap;
         if (rows[i].h || rows[i].v) do_step(rows[i].h, rows[i].v);
         do_eval(rows[i].md, rows[i].sr, rows[i].op, rows[i].seed);
      end
      // a step beside a load is dropped
      set_model(1'b0);
      load_eqs(1'b1);
      do_eval(PEI_MODE_SINGLE, PEI_SRC_COLOR, PEI_OP_PASS, 8'h33);
      do_eval(PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_PASS, 8'h44);
      // back to back evals, answered in order
      far.present(8'h77);
      m = far.mem_out;
      {lane_mode_in, source_in, op_in} = {PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_ADD};
      eval_in = 1'b1;
      @(negedge clock_in);
      op_in = PEI_OP_SUB;
      @(negedge clock_in);
      eval_in = 1'b0;
      far.release_bus();
      check_eval(m, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_ADD);
      @(negedge clock_in);
      check_eval(m, PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_SUB);
      @(negedge clock_in);
      check("valid drop", 27'(result_valid_out), 27'h0);
      // reset in mid run clears outputs and planes
      rst_in = 1'b1;
      repeat (2) @(negedge clock_in);
      rst_in = 1'b0;
      check_idle();
      set_model(1'b1);
      do_eval(PEI_MODE_TRIPLE, PEI_SRC_COLOR, PEI_OP_ADD, 8'h9e);
      results();
   end
endmodule

bind pei_plane_interp pei_plane_interp_sva u_sva (
   .clock_in(clock_in), .rst_in(rst_in), .eval_in(eval_in), .lane_mode_in(lane_mode_in),
   .source_in(source_in), .op_in(op_in), .mem_rd_data_in(mem_rd_data_in),
   .result_out(result_out), .flag_out(flag_out), .result_valid_out(result_valid_out));
